// ===== design/fault_resp_pkg.sv
// shared constants and types of the sensor fault-response block
// assumes a single 100 MHz core clock and a chip-level power-on reset
package fault_resp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int SP_W = 16;
  localparam int ROM_W = 8;
  localparam int N_ASYNC = 7;
  localparam int SSM_BIT = 7;
  // async input vector positions
  localparam int AS_VOLT = 0;
  localparam int AS_FREQ = 1;
  localparam int AS_TEMP = 2;
  localparam int AS_LIGHT = 3;
  localparam int AS_EEL_A = 4;
  localparam int AS_EEL_B = 5;
  localparam int AS_HV_OK = 6;
  // reset cause bits
  localparam int CAUSE_W = 6;
  localparam int CA_POWER = 0;
  localparam int CA_VOLT = 1;
  localparam int CA_PARITY = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_POR = 6'h01;
  // exception reason bits
  localparam int REASON_W = 9;
  localparam int RS_EE_LIGHT = 0;
  localparam int RS_STACK = 1;
  localparam int RS_SFI = 4;
  // stack modes
  localparam int MD_USER = 0;
  localparam int MD_SYS = 1;
  localparam int MD_SSM = 2;
  localparam logic [SP_W-1:0] SP_LO_DEF = 16'h0100;
  localparam logic [SP_W-1:0] SP_HI_DEF = 16'h01FF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SSM_BOOT, SSM_TEST, SSM_APP} ssm_mode_t;
  typedef enum logic [1:0] {EEL_OFF, EEL_A, EEL_B, EEL_OFF2} eel_sel_t;

  typedef struct packed {
    logic volt;
    logic freq;
    logic temp;
    logic light;
  } env_alarm_t;

  typedef struct packed {
    logic arith;
    logic des;
    logic status;
    logic sp;
    logic pc;
  } sfi_alarm_t;

  typedef struct packed {
    logic [N_ASYNC-1:0] sync1;
    logic [N_ASYNC-1:0] sync2;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic rst_active;
    logic [CAUSE_W-1:0] cause;
    logic [REASON_W-1:0] reason;
    logic exc;
    logic [2:0][SP_W-1:0] sp;
    ssm_mode_t ssm;
    logic sens_on;
    logic wr_prev;
    logic hv_fail;
  } state_t;

endpackage : fault_resp_pkg

// ===== design/fault_resp.sv
// sensor alarm gathering, forced reset, exception and cause indication
// assumes sensor pins are asynchronous; core-side strobes share i_clk
`timescale 1ns/100ps
`default_nettype none

module fault_resp #(
  parameter logic [fault_resp_pkg::SP_W-1:0] SP_LO = fault_resp_pkg::SP_LO_DEF,
  parameter logic [fault_resp_pkg::SP_W-1:0] SP_HI = fault_resp_pkg::SP_HI_DEF,
  parameter bit TEST_LOCKED = 1'b1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // analog sensor alarms, asynchronous
  input wire fault_resp_pkg::env_alarm_t i_env_alarm,
  input wire logic i_ee_light_a,
  input wire logic i_ee_light_b,
  input wire logic i_ee_hv_ok,
  // core-side fault detectors and configuration
  input wire fault_resp_pkg::sfi_alarm_t i_sfi_alarm,
  input wire fault_resp_pkg::eel_sel_t i_ee_light_sel,
  input wire logic i_sensor_off_req,
  input wire logic i_ee_write_active,
  input wire logic i_boot_done,
  // processor mode and stack traffic
  input wire logic [7:0] i_processor_status_high_byte,
  input wire logic i_system_mode,
  input wire logic i_sp_push,
  input wire logic i_sp_pop,
  // rom read check
  input wire logic i_rom_rd_valid,
  input wire logic [fault_resp_pkg::ROM_W-1:0] i_rom_rd_data,
  input wire logic i_rom_rd_parity,
  // software clears of the sticky indicators
  input wire logic [fault_resp_pkg::CAUSE_W-1:0] i_cause_clr,
  input wire logic [fault_resp_pkg::REASON_W-1:0] i_reason_clr,
  // results
  output logic o_chip_reset_n,
  output logic o_exception,
  output logic [fault_resp_pkg::CAUSE_W-1:0] o_reset_cause,
  output logic [fault_resp_pkg::REASON_W-1:0] o_exc_reason,
  output logic o_ee_hv_fail,
  output logic o_sensors_on,
  output fault_resp_pkg::ssm_mode_t o_ssm_mode,
  output logic [2:0][fault_resp_pkg::SP_W-1:0] o_sp
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam fault_resp_pkg::state_t ST_RESET = '{
    sync1: '0, sync2: '0, rst_cnt: '0, rst_active: 1'b0,
    cause: fault_resp_pkg::CAUSE_POR, reason: '0, exc: 1'b0,
    sp: {3{SP_LO}}, ssm: fault_resp_pkg::SSM_BOOT, sens_on: 1'b1,
    wr_prev: 1'b0, hv_fail: 1'b0};

  fault_resp_pkg::state_t r;
  fault_resp_pkg::state_t n;
  logic [fault_resp_pkg::N_ASYNC-1:0] async_in;
  logic [fault_resp_pkg::CAUSE_W-1:0] rst_src;
  logic [fault_resp_pkg::REASON_W-1:0] ev;
  logic parity_err;
  logic eel_hit;
  logic [1:0] md;

  assign async_in = {i_ee_hv_ok, i_ee_light_b, i_ee_light_a, i_env_alarm.light,
                     i_env_alarm.temp, i_env_alarm.freq, i_env_alarm.volt};
  // even parity over data plus parity bit
  assign parity_err = i_rom_rd_valid & (^{i_rom_rd_data, i_rom_rd_parity});

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.sync1 = async_in;
    n.sync2 = r.sync1;
    // fixed wiring; no software input reaches this vector
    rst_src = '0;
    rst_src[fault_resp_pkg::CA_VOLT +: 4] = r.sync2[fault_resp_pkg::AS_VOLT +: 4]
                                            & {4{r.sens_on}};
    rst_src[fault_resp_pkg::CA_PARITY] = parity_err;
    // mode of the active stack pointer
    if (i_processor_status_high_byte[fault_resp_pkg::SSM_BIT]) begin
      md = 2'(fault_resp_pkg::MD_SSM);
    end else if (i_system_mode) begin
      md = 2'(fault_resp_pkg::MD_SYS);
    end else begin
      md = 2'(fault_resp_pkg::MD_USER);
    end
    case (i_ee_light_sel)
      fault_resp_pkg::EEL_A: eel_hit = r.sync2[fault_resp_pkg::AS_EEL_A];
      fault_resp_pkg::EEL_B: eel_hit = r.sync2[fault_resp_pkg::AS_EEL_B];
      default: eel_hit = 1'b0;
    endcase
    ev = '0;
    ev[fault_resp_pkg::RS_EE_LIGHT] = eel_hit & r.sens_on;
    ev[fault_resp_pkg::RS_SFI +: 5] = i_sfi_alarm;
    n.exc = 1'b0;
    if (|rst_src) begin
      // forced reset: everything back to reset values except the cause record and the sync chain
      n = ST_RESET;
      n.sync1 = async_in;
      n.sync2 = r.sync1;
      n.rst_active = 1'b1;
      n.rst_cnt = fault_resp_pkg::RST_CYC[fault_resp_pkg::RST_CNT_W-1:0];
    end else if (r.rst_active) begin
      n = ST_RESET;
      n.sync1 = async_in;
      n.sync2 = r.sync1;
      n.rst_cnt = r.rst_cnt - 1'b1;
      n.rst_active = (r.rst_cnt != 1);
    end else begin
      // super system sub-mode; boot is re-entered only through a forced or power-on reset
      case (r.ssm)
        fault_resp_pkg::SSM_BOOT: begin
          if (i_boot_done) begin
            n.ssm = TEST_LOCKED ? fault_resp_pkg::SSM_APP : fault_resp_pkg::SSM_TEST;
          end
        end
        fault_resp_pkg::SSM_TEST: n.ssm = fault_resp_pkg::SSM_TEST;
        fault_resp_pkg::SSM_APP: n.ssm = fault_resp_pkg::SSM_APP;
        default: n.ssm = fault_resp_pkg::SSM_APP;
      endcase
      // the off request has no path into sens_on
      n.sens_on = (n.ssm != fault_resp_pkg::SSM_TEST) | i_sensor_off_req & 1'b0;
      // stack pointer of the active mode; a move past a limit is refused
      if (i_sp_push && !i_sp_pop) begin
        if (r.sp[md] == SP_HI) begin
          ev[fault_resp_pkg::RS_STACK + md] = 1'b1;
        end else begin
          n.sp[md] = r.sp[md] + 1'b1;
        end
      end else if (i_sp_pop && !i_sp_push) begin
        if (r.sp[md] == SP_LO) begin
          ev[fault_resp_pkg::RS_STACK + md] = 1'b1;
        end else begin
          n.sp[md] = r.sp[md] - 1'b1;
        end
      end
      // high-voltage flag: cleared at the start of a write, set while low
      n.wr_prev = i_ee_write_active;
      if (i_ee_write_active && !r.wr_prev) begin
        n.hv_fail = 1'b0;
      end
      if (i_ee_write_active && !r.sync2[fault_resp_pkg::AS_HV_OK]) begin
        n.hv_fail = 1'b1;
      end
      // set wins over a clear in the same cycle
      n.reason = (r.reason & ~i_reason_clr) | ev;
      n.exc = |ev;
    end
    // cause survives the forced reset; only power-on or i_cause_clr clears it
    n.cause = (r.cause & ~i_cause_clr) | rst_src;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_chip_reset_n = ~r.rst_active;
  assign o_exception = r.exc;
  assign o_reset_cause = r.cause;
  assign o_exc_reason = r.reason;
  assign o_ee_hv_fail = r.hv_fail;
  assign o_sensors_on = r.sens_on;
  assign o_ssm_mode = r.ssm;
  assign o_sp = r.sp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_env_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      (r.sync2[fault_resp_pkg::AS_VOLT] && r.sens_on)
      |=> (!o_chip_reset_n && o_reset_cause[fault_resp_pkg::CA_VOLT]);
  endproperty
  a_env_reset: assert property (p_env_reset) else $error("voltage alarm gave no reset");

  property p_parity_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      parity_err |=> (!o_chip_reset_n && o_reset_cause[fault_resp_pkg::CA_PARITY]);
  endproperty
  a_parity_reset: assert property (p_parity_reset) else $error("parity error gave no reset");

  property p_sfi_exc;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_chip_reset_n && i_sfi_alarm.pc && rst_src == '0)
      |=> (o_exception && o_chip_reset_n && o_exc_reason[fault_resp_pkg::RS_SFI]);
  endproperty
  a_sfi_exc: assert property (p_sfi_exc) else $error("fault alarm gave no exception");

  property p_reset_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      $fell(o_chip_reset_n) |-> (!o_chip_reset_n && o_exc_reason == '0) [*8];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("forced reset too short");

  property p_cause_sticky;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_reset_cause[fault_resp_pkg::CA_PARITY] && !i_cause_clr[fault_resp_pkg::CA_PARITY])
      |=> o_reset_cause[fault_resp_pkg::CA_PARITY];
  endproperty
  a_cause_sticky: assert property (p_cause_sticky) else $error("cause bit lost");

  property p_hv_flag;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_chip_reset_n && rst_src == '0 && i_ee_write_active
       && !r.sync2[fault_resp_pkg::AS_HV_OK])
      |=> (o_ee_hv_fail && o_chip_reset_n);
  endproperty
  a_hv_flag: assert property (p_hv_flag) else $error("high voltage fault not flagged");

  property p_stack_limit;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_chip_reset_n && rst_src == '0 && md == 2'(fault_resp_pkg::MD_USER)
       && i_sp_push && !i_sp_pop && o_sp[fault_resp_pkg::MD_USER] == SP_HI)
      |=> (o_exception && o_exc_reason[fault_resp_pkg::RS_STACK]
           && o_sp[fault_resp_pkg::MD_USER] == SP_HI);
  endproperty
  a_stack_limit: assert property (p_stack_limit) else $error("stack limit not trapped");

  property p_no_test;
    @(posedge i_clk) disable iff (!i_reset_n)
      TEST_LOCKED |-> (o_ssm_mode != fault_resp_pkg::SSM_TEST && o_sensors_on);
  endproperty
  a_no_test: assert property (p_no_test) else $error("test mode or sensors off");

  // an alarm that starts a forced reset is always recorded, even under a clear
  property p_cause_record;
    @(posedge i_clk) disable iff (!i_reset_n)
      (rst_src != '0) |=> ((o_reset_cause & $past(rst_src)) == $past(rst_src));
  endproperty
  a_cause_record: assert property (p_cause_record) else $error("cause missed");

  property p_reason_record;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_chip_reset_n && rst_src == '0 && ev != '0)
      |=> (o_exception && (o_exc_reason & $past(ev)) == $past(ev));
  endproperty
  a_reason_record: assert property (p_reason_record) else $error("reason missed");

  property p_ee_light_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_ee_light_sel == fault_resp_pkg::EEL_OFF || i_ee_light_sel == fault_resp_pkg::EEL_OFF2)
      |-> !ev[fault_resp_pkg::RS_EE_LIGHT];
  endproperty
  a_ee_light_off: assert property (p_ee_light_off) else $error("deselected light fired");

  // the high-voltage flag and other quiet inputs never raise an exception
  property p_exc_sources;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_sfi_alarm == '0 && !eel_hit && !i_sp_push && !i_sp_pop) |=> !o_exception;
  endproperty
  a_exc_sources: assert property (p_exc_sources) else $error("stray exception");

  property p_boot_once;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_ssm_mode != fault_resp_pkg::SSM_BOOT && rst_src == '0)
      |=> (o_ssm_mode != fault_resp_pkg::SSM_BOOT);
  endproperty
  a_boot_once: assert property (p_boot_once) else $error("boot re-entered");

  property p_sys_stack_floor;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_chip_reset_n && rst_src == '0 && md == 2'(fault_resp_pkg::MD_SYS)
       && i_sp_pop && !i_sp_push && o_sp[fault_resp_pkg::MD_SYS] == SP_LO)
      |=> (o_exception && o_exc_reason[fault_resp_pkg::RS_STACK + fault_resp_pkg::MD_SYS]
           && o_sp[fault_resp_pkg::MD_SYS] == SP_LO);
  endproperty
  a_sys_stack_floor: assert property (p_sys_stack_floor) else $error("floor miss");

  c_env_reset: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_chip_reset_n) ##1 o_reset_cause[fault_resp_pkg::CA_VOLT]);
  c_sfi_exc: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_exception && o_exc_reason[fault_resp_pkg::RS_SFI + 3]);
  c_boot_exit: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_ssm_mode == fault_resp_pkg::SSM_BOOT ##1 o_ssm_mode == fault_resp_pkg::SSM_APP);
  c_stack_trap: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_exception && o_exc_reason[fault_resp_pkg::RS_STACK + fault_resp_pkg::MD_SSM]);
  c_hv_fail: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_ee_hv_fail) && o_chip_reset_n);

endmodule : fault_resp

`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the sensor fault-response block
// assumes the package and design are compiled first; bench drives all inputs
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------
  // a four-entry stack range lets both limits be reached in a few moves
  localparam logic [15:0] SP_TOP = fault_resp_pkg::SP_LO_DEF + 16'h0003;
  logic i_clk, i_reset_n, i_ee_light_a, i_ee_light_b, i_ee_hv_ok, i_sensor_off_req;
  logic i_ee_write_active, i_boot_done, i_system_mode, i_sp_push, i_sp_pop;
  logic i_rom_rd_valid, i_rom_rd_parity, o_chip_reset_n, o_exception, o_ee_hv_fail;
  logic o_sensors_on;
  logic [7:0] i_processor_status_high_byte, i_rom_rd_data;
  logic [5:0] i_cause_clr, o_reset_cause;
  logic [8:0] i_reason_clr, o_exc_reason;
  logic [2:0][15:0] o_sp;
  fault_resp_pkg::env_alarm_t i_env_alarm;
  fault_resp_pkg::sfi_alarm_t i_sfi_alarm;
  fault_resp_pkg::eel_sel_t i_ee_light_sel;
  fault_resp_pkg::ssm_mode_t o_ssm_mode;
  int seed, mismatches, n_checks, k;

  fault_resp #(.SP_HI(SP_TOP)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_env_alarm(i_env_alarm),
    .i_ee_light_a(i_ee_light_a), .i_ee_light_b(i_ee_light_b), .i_ee_hv_ok(i_ee_hv_ok),
    .i_sfi_alarm(i_sfi_alarm), .i_ee_light_sel(i_ee_light_sel),
    .i_sensor_off_req(i_sensor_off_req), .i_ee_write_active(i_ee_write_active),
    .i_boot_done(i_boot_done), .i_processor_status_high_byte(i_processor_status_high_byte),
    .i_system_mode(i_system_mode), .i_sp_push(i_sp_push), .i_sp_pop(i_sp_pop),
    .i_rom_rd_valid(i_rom_rd_valid), .i_rom_rd_data(i_rom_rd_data),
    .i_rom_rd_parity(i_rom_rd_parity), .i_cause_clr(i_cause_clr), .i_reason_clr(i_reason_clr),
    .o_chip_reset_n(o_chip_reset_n), .o_exception(o_exception), .o_reset_cause(o_reset_cause),
    .o_exc_reason(o_exc_reason), .o_ee_hv_fail(o_ee_hv_fail), .o_sensors_on(o_sensors_on),
    .o_ssm_mode(o_ssm_mode), .o_sp(o_sp)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic clr();
    i_cause_clr = 6'h3F;
    i_reason_clr = 9'h1FF;
    @(negedge i_clk);
    i_cause_clr = 6'h00;
    i_reason_clr = 9'h000;
    @(negedge i_clk);
  endtask : clr

  task automatic quiet(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(negedge i_clk);
      if (o_exception !== 1'b0 || o_chip_reset_n !== 1'b1) seen++;
    end
    chk("no_event", 0, seen);
  endtask : quiet

  // measures the forced reset length, then the sticky cause and its clear
  task automatic see_reset(input int bitn);
    int n, lo;
    n = 0;
    lo = 0;
    while (o_chip_reset_n !== 1'b0 && n < 10) begin
      @(negedge i_clk);
      n++;
    end
    while (o_chip_reset_n === 1'b0 && lo < 300) begin
      @(negedge i_clk);
      lo++;
    end
    if (n >= 10 || lo >= 300) begin
      mismatches++;
      final_report();
    end
    chk("reset_len", fault_resp_pkg::RST_CYC, lo);
    quiet(3);
    chk("cause", 6'h01 << bitn, o_reset_cause);
    clr();
    chk("cause_clr", 0, o_reset_cause);
  endtask : see_reset

  // lat below zero skips the latency compare
  task automatic exc_wait(input int lat, input int bitn);
    int n;
    n = 0;
    while (o_exception !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 8) begin
      mismatches++;
      final_report();
    end
    if (lat >= 0) chk("exc_latency", lat, n);
    @(negedge i_clk);
    chk("exc_pulse", 0, o_exception);
    chk("reason", 9'h001 << bitn, o_exc_reason);
    clr();
    chk("reason_clr", 0, o_exc_reason);
  endtask : exc_wait

  // idle cycle first, so back-to-back moves never retouch a strobe in one step and
  // the one-cycle exception pulse of a refused move still stands on return
  task automatic sp_move(input logic [1:0] mv);
    @(negedge i_clk);
    {i_sp_push, i_sp_pop} = mv;
    @(negedge i_clk);
    {i_sp_push, i_sp_pop} = 2'h0;
  endtask : sp_move

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 16153;
    mismatches = 0;
    n_checks = 0;
    {i_reset_n, i_ee_light_a, i_ee_light_b, i_ee_write_active, i_boot_done} = 5'h00;
    {i_system_mode, i_sp_push, i_sp_pop, i_rom_rd_valid, i_rom_rd_parity} = 5'h00;
    {i_processor_status_high_byte, i_rom_rd_data, i_cause_clr, i_reason_clr} = '0;
    i_env_alarm = '0;
    i_sfi_alarm = '0;
    i_ee_light_sel = fault_resp_pkg::EEL_OFF;
    i_ee_hv_ok = 1'b1;
    // software keeps asking to switch the sensors off for the whole run
    i_sensor_off_req = 1'b1;
    repeat (16) @(negedge i_clk);
    i_reset_n = 1'b1;
    @(negedge i_clk);
    chk("por_cause", fault_resp_pkg::CAUSE_POR, o_reset_cause);
    chk("por_state", 4'b1001, {o_chip_reset_n, o_exception, o_ee_hv_fail, o_sensors_on});
    chk("por_reason", 0, o_exc_reason);
    chk("por_sp", {3{fault_resp_pkg::SP_LO_DEF}}, o_sp);
    chk("por_mode", fault_resp_pkg::SSM_BOOT, o_ssm_mode);
    i_boot_done = 1'b1;
    @(negedge i_clk);
    i_boot_done = 1'b0;
    @(negedge i_clk);
    chk("app_mode", fault_resp_pkg::SSM_APP, o_ssm_mode);
    clr();
    for (int b = 0; b < 4; b++) begin
      i_env_alarm = fault_resp_pkg::env_alarm_t'(4'h1 << b);
      @(negedge i_clk);
      i_env_alarm = '0;
      see_reset(4 - b);
    end
    for (int b = 0; b < 5; b++) begin
      i_sfi_alarm = fault_resp_pkg::sfi_alarm_t'(5'h01 << b);
      @(negedge i_clk);
      i_sfi_alarm = '0;
      exc_wait(0, 4 + b);
    end
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 2; d++) begin
        i_ee_light_sel = fault_resp_pkg::eel_sel_t'(s[1:0]);
        @(negedge i_clk);
        {i_ee_light_b, i_ee_light_a} = 2'(1 << d);
        @(negedge i_clk);
        {i_ee_light_b, i_ee_light_a} = 2'b00;
        if ((s == 1 && d == 0) || (s == 2 && d == 1)) begin
          exc_wait(2, fault_resp_pkg::RS_EE_LIGHT);
        end else begin
          quiet(8);
        end
      end
    end
    i_ee_write_active = 1'b1;
    i_ee_hv_ok = 1'b0;
    quiet(6);
    chk("hv_fail", 1, o_ee_hv_fail);
    i_ee_write_active = 1'b0;
    i_ee_hv_ok = 1'b1;
    quiet(4);
    chk("hv_hold", 1, o_ee_hv_fail);
    i_ee_write_active = 1'b1;
    quiet(4);
    chk("hv_new_write", 0, o_ee_hv_fail);
    i_ee_write_active = 1'b0;
    for (int m = 0; m < 3; m++) begin
      i_processor_status_high_byte = (m == 2) ? 8'h80 : 8'h00;
      i_system_mode = (m == 1);
      sp_move(2'h1);
      exc_wait(0, 1 + m);
      chk("sp_floor", fault_resp_pkg::SP_LO_DEF, o_sp[m]);
      repeat (3) sp_move(2'h2);
      chk("sp_top", SP_TOP, o_sp[m]);
      sp_move(2'h2);
      exc_wait(0, 1 + m);
      sp_move(2'h3);
      chk("sp_hold", SP_TOP, o_sp[m]);
      k = 1 + (($random(seed) & 32'h7FFF_FFFF) % 3);
      repeat (k) sp_move(2'h1);
      chk("sp_rand", SP_TOP - 16'(k), o_sp[m]);
    end
    for (int i = 0; i < 6; i++) begin
      i_rom_rd_data = 8'($random(seed));
      i_rom_rd_parity = (^i_rom_rd_data) ^ (i == 5);
      i_rom_rd_valid = 1'b1;
      @(negedge i_clk);
      i_rom_rd_valid = 1'b0;
      if (i < 5) quiet(3);
      else see_reset(fault_resp_pkg::CA_PARITY);
    end
    chk("sensors_on", 1, o_sensors_on);
    final_report();
  end
endmodule : tb_top

`default_nettype wire
